// ### rtl/rms_engine_pkg.sv
// shared constants for the polyphase rms engine: register map, field positions,
// channel order and sequencer states
// assumes one 40 MHz clock and an 8 kHz sample strobe from the sample datapath
package rms_engine_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int IN_W = 24;
    localparam int SMP_W = 28;
    localparam int RES_W = 24;
    localparam int NCH = 18;
    localparam int CH_W = 5;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int SAMPLE_HZ = 8_000;
    localparam int SETTLE_MS = 580;
    localparam int LPF_SHIFT_DEF = 9;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_ACCUMULATION_MODE_CONFIG = 16'hE701;
    localparam logic [15:0] ADDR_CONFIG = 16'hE618;
    localparam logic [15:0] RES_BASE = 16'h43C0;
    localparam logic [15:0] OFF_BASE = 16'h4380;
    localparam logic [7:0] ACCUMULATION_MODE_CONFIG_RST = 8'h00;
    localparam logic [15:0] CONFIG_RST = 16'h0000;
    localparam int NSEL_BIT = 14;
    localparam int TOPO_LSB = 4;
    localparam int TOPO_W = 2;
    localparam logic [1:0] TOPO_DELTA3W = 2'h1;
    localparam logic [1:0] TOPO_DELTA4W = 2'h3;
    localparam int OFF_SHIFT = 7;
    localparam logic [RES_W-1:0] RES_MAX = 24'h7FFFFF;

    // ------------------------------------------------------------------
    // channel order, also the register index within each block
    // ------------------------------------------------------------------
    localparam int CH_IA = 0;
    localparam int CH_IB = 1;
    localparam int CH_IC = 2;
    localparam int CH_IN = 3;
    localparam int CH_VA = 4;
    localparam int CH_VB = 5;
    localparam int CH_VC = 6;
    localparam int CH_VN = 7;
    localparam int CH_VA2 = 8;
    localparam int CH_VB2 = 9;
    localparam int CH_VC2 = 10;
    localparam int CH_VN2 = 11;
    localparam int CH_FIA = 12;
    localparam int CH_FIB = 13;
    localparam int CH_FIC = 14;
    localparam int CH_FVA = 15;
    localparam int CH_FVB = 16;
    localparam int CH_FVC = 17;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FILT = 3'b010,
        ST_ROOT = 3'b100
    } seq_state_t;

endpackage

// ### rtl/rms_sqrt.sv
// iterative integer square root, two radicand bits per clock
// assumes the caller holds off i_start while o_busy is high
`timescale 1ns/1ps
module rms_sqrt #(
    parameter int RAD_W = 56
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic [RAD_W-1:0] i_radicand,
    output logic [RAD_W/2-1:0] o_root,
    output logic o_done,
    output logic o_busy
);

    // ------------------------------------------------------------------
    // digit recurrence
    // ------------------------------------------------------------------
    localparam logic [RAD_W-1:0] BIT_TOP = {2'b01, {(RAD_W-2){1'b0}}};
    localparam logic [RAD_W-1:0] BIT_ONE = {{(RAD_W-1){1'b0}}, 1'b1};

    logic [RAD_W-1:0] rem_r;
    logic [RAD_W-1:0] acc_r;
    logic [RAD_W-1:0] bit_r;
    logic busy_r;
    logic done_r;
    logic [RAD_W-1:0] trial;

    assign trial = acc_r + bit_r;

    // one result bit per cycle, radicand top bits first
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rem_r <= '0;
            acc_r <= '0;
            bit_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (i_start && !busy_r) begin
                rem_r <= i_radicand;
                acc_r <= '0;
                bit_r <= BIT_TOP;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (rem_r >= trial) begin
                    rem_r <= rem_r - trial;
                    acc_r <= (acc_r >> 1) + bit_r;
                end else begin
                    acc_r <= acc_r >> 1;
                end
                bit_r <= bit_r >> 2;
                if (bit_r == BIT_ONE) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end

    // root is valid while o_done is high and holds until the next start
    assign o_root = acc_r[RAD_W/2-1:0];
    assign o_done = done_r;
    assign o_busy = busy_r;

endmodule

// ### rtl/polyphase_rms_engine.sv
// polyphase rms engine: total and fundamental rms of currents and voltages
// assumes one sample strobe per 8 kHz period with all channel samples valid
// beside it, and a single-cycle register read/write port on i_clk
//
// Operation
// RL1: 24-bit current rms per phase, neutral, 8 kHz
// RL2: 24-bit voltage, secondary, neutral rms at 8 kHz
// RL3: fundamental rms for three currents, three voltages
// RL4: select bit low: neutral rms from neutral current
// RL5: select bit high: neutral rms from phase sum
// RL6: full-scale sinusoid gives 3,761,808, no gain
// RL7: current rms settles from zero within 580 ms
// RL8: voltage rms settles from zero within 580 ms
// RL9: all content up to 3.3 kHz contributes
// RL10: rms reads as 32 bits, top eight zero
// RL11: current offset times 128 added before root
// RL12: voltage offset times 128 added before root
// RL13: one signed 24-bit offset per current channel
// RL14: offset reads sign-extended to 28, four zeros
// RL15: 3-wire delta: phase B gets A minus C
// RL16: 3-wire delta forces phase B powers zero
// RL17: phase B calibration acts on synthesized voltage
// RL18: 4-wire delta: phase B gets negated A
// RL19: reader averages rms readings over one second
// RL20: calibrate offsets with small nonzero current
// RL21: square, low-pass filter, then square root
// RL22: negative radicand clamps to zero
`timescale 1ns/1ps
module polyphase_rms_engine #(
    parameter int LPF_SHIFT = rms_engine_pkg::LPF_SHIFT_DEF
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sample_strobe,
    input wire logic signed [23:0] i_ia,
    input wire logic signed [23:0] i_ib,
    input wire logic signed [23:0] i_ic,
    input wire logic signed [23:0] i_in,
    input wire logic signed [23:0] i_va,
    input wire logic signed [23:0] i_vb,
    input wire logic signed [23:0] i_vc,
    input wire logic signed [23:0] i_vn,
    input wire logic signed [23:0] i_va2,
    input wire logic signed [23:0] i_vb2,
    input wire logic signed [23:0] i_vc2,
    input wire logic signed [23:0] i_vn2,
    input wire logic signed [23:0] i_ia_fund,
    input wire logic signed [23:0] i_ib_fund,
    input wire logic signed [23:0] i_ic_fund,
    input wire logic signed [23:0] i_va_fund,
    input wire logic signed [23:0] i_vb_fund,
    input wire logic signed [23:0] i_vc_fund,
    input wire logic signed [23:0] i_va_raw,
    input wire logic signed [23:0] i_vb_raw,
    input wire logic signed [23:0] i_vc_raw,
    input wire logic [15:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic signed [24:0] o_vb_synth,
    output logic o_phase_b_power_zero,
    output logic o_frame_done,
    output logic o_busy
);

    // ------------------------------------------------------------------
    // local sizes and helpers
    // ------------------------------------------------------------------
    localparam int SMP_W = rms_engine_pkg::SMP_W;
    localparam int IN_W = rms_engine_pkg::IN_W;
    localparam int RES_W = rms_engine_pkg::RES_W;
    localparam int NCH = rms_engine_pkg::NCH;
    localparam int CH_W = rms_engine_pkg::CH_W;
    localparam int RAD_W = 2 * SMP_W;
    localparam int ACC_W = RAD_W + LPF_SHIFT;
    localparam int SUM_W = RAD_W + 2;
    localparam int ROOT_W = RAD_W / 2;
    localparam int FRAME_BOUND = 700;
    localparam int ROOT_BOUND = 40;
    localparam logic [CH_W-1:0] CH_LAST = CH_W'(NCH - 1);

    function automatic logic signed [SMP_W-1:0] sx(input logic signed [IN_W-1:0] v);
        sx = SMP_W'(v);
    endfunction

    function automatic logic in_block(input logic [15:0] a, input logic [15:0] base);
        in_block = (a >= base) && (a < base + 16'(NCH));
    endfunction

    function automatic logic [CH_W-1:0] blk_idx(input logic [15:0] a,
                                                 input logic [15:0] base);
        logic [15:0] d;
        d = a - base;
        blk_idx = d[CH_W-1:0];
    endfunction

    function automatic logic [RES_W-1:0] sat_res(input logic [ROOT_W-1:0] r);
        sat_res = (r > ROOT_W'(rms_engine_pkg::RES_MAX)) ? rms_engine_pkg::RES_MAX
                                                         : r[RES_W-1:0];
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] accumulation_mode_config_r;
    logic [15:0] config_r;
    logic signed [IN_W-1:0] off_r [NCH];
    logic [RES_W-1:0] res_r [NCH];
    logic [ACC_W-1:0] acc_r [NCH];
    logic signed [SMP_W-1:0] smp_r [NCH];
    logic [CH_W-1:0] ch_r;
    rms_engine_pkg::seq_state_t state_r;
    logic [31:0] rdata_r;
    logic rvalid_r;
    logic signed [24:0] vb_synth_r;
    logic signed [24:0] vb_synth_nxt;
    logic frame_done_r;

    logic [1:0] topology;
    logic nsel;
    logic frame_start;
    logic signed [24:0] diff_3w;
    logic signed [24:0] neg_4w;
    logic signed [SMP_W-1:0] isum;
    logic signed [SMP_W-1:0] in_ext;

    assign topology = accumulation_mode_config_r[rms_engine_pkg::TOPO_LSB +: rms_engine_pkg::TOPO_W];
    assign nsel = config_r[rms_engine_pkg::NSEL_BIT];
    assign frame_start = i_sample_strobe && (state_r == rms_engine_pkg::ST_IDLE);
    assign isum = sx(i_ia) + sx(i_ib) + sx(i_ic);
    assign in_ext = sx(i_in);

    // ------------------------------------------------------------------
    // phase B voltage routing in delta wiring
    // ------------------------------------------------------------------
    assign diff_3w = 25'(i_va_raw) - 25'(i_vc_raw);
    assign neg_4w = -25'(i_va_raw);

    // raw samples enter here, before any gain or phase compensation
    always_comb begin
        case (topology)
            rms_engine_pkg::TOPO_DELTA3W: vb_synth_nxt = diff_3w; // [RL15]
            rms_engine_pkg::TOPO_DELTA4W: vb_synth_nxt = neg_4w; // [RL18]
            default: vb_synth_nxt = 25'(i_vb_raw);
        endcase
    end

    // routed sample goes back out through phase B gain and phase calibration
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            vb_synth_r <= '0;
        end else if (frame_start) begin
            vb_synth_r <= vb_synth_nxt; // [RL15] [RL18] [RL17]
        end
    end

    // phase B powers are blanked while the 3-wire delta code is set
    assign o_phase_b_power_zero = (topology == rms_engine_pkg::TOPO_DELTA3W); // [RL16]

    // ------------------------------------------------------------------
    // sample capture, one snapshot per strobe
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            for (int k = 0; k < NCH; k++) begin
                smp_r[k] <= '0;
            end
        end else if (frame_start) begin
            smp_r[rms_engine_pkg::CH_IA] <= sx(i_ia); // [RL1]
            smp_r[rms_engine_pkg::CH_IB] <= sx(i_ib);
            smp_r[rms_engine_pkg::CH_IC] <= sx(i_ic);
            smp_r[rms_engine_pkg::CH_IN] <= nsel ? isum : in_ext; // [RL4] [RL5]
            smp_r[rms_engine_pkg::CH_VA] <= sx(i_va); // [RL2]
            smp_r[rms_engine_pkg::CH_VB] <= sx(i_vb); // [RL17]
            smp_r[rms_engine_pkg::CH_VC] <= sx(i_vc);
            smp_r[rms_engine_pkg::CH_VN] <= sx(i_vn);
            smp_r[rms_engine_pkg::CH_VA2] <= sx(i_va2);
            smp_r[rms_engine_pkg::CH_VB2] <= sx(i_vb2);
            smp_r[rms_engine_pkg::CH_VC2] <= sx(i_vc2);
            smp_r[rms_engine_pkg::CH_VN2] <= sx(i_vn2);
            smp_r[rms_engine_pkg::CH_FIA] <= sx(i_ia_fund); // [RL3]
            smp_r[rms_engine_pkg::CH_FIB] <= sx(i_ib_fund);
            smp_r[rms_engine_pkg::CH_FIC] <= sx(i_ic_fund);
            smp_r[rms_engine_pkg::CH_FVA] <= sx(i_va_fund);
            smp_r[rms_engine_pkg::CH_FVB] <= sx(i_vb_fund); // [RL17]
            smp_r[rms_engine_pkg::CH_FVC] <= sx(i_vc_fund);
        end
    end

    // ------------------------------------------------------------------
    // square, low-pass, offset and clamp for the channel in hand
    // ------------------------------------------------------------------
    logic signed [SMP_W-1:0] cur_smp;
    logic signed [RAD_W-1:0] sq_s;
    logic [ACC_W-1:0] acc_new;
    logic [RAD_W-1:0] mean_new;
    logic signed [SUM_W-1:0] off_ext;
    logic signed [SUM_W-1:0] off_scaled;
    logic signed [SUM_W-1:0] rad_sum;
    logic [RAD_W-1:0] radicand;
    logic root_start;
    logic [ROOT_W-1:0] root_val;
    logic root_done;

    // every sample is squared unfiltered, so harmonics stay in the mean
    assign cur_smp = smp_r[ch_r];
    assign sq_s = cur_smp * cur_smp; // [RL21] [RL9]
    // single pole mean of the square; shift sets the settling time
    assign acc_new = acc_r[ch_r] + ACC_W'($unsigned(sq_s)) - (acc_r[ch_r] >> LPF_SHIFT); // [RL7] [RL8]
    assign mean_new = acc_new[ACC_W-1:LPF_SHIFT];
    assign off_ext = SUM_W'(off_r[ch_r]);
    assign off_scaled = off_ext <<< rms_engine_pkg::OFF_SHIFT; // [RL11] [RL12]
    assign rad_sum = $signed({2'b00, mean_new}) + off_scaled;
    assign radicand = rad_sum[SUM_W-1] ? '0 : rad_sum[RAD_W-1:0]; // [RL22]
    assign root_start = (state_r == rms_engine_pkg::ST_FILT);

    // the mean square is kept unscaled, so the root lands on the sample scale
    rms_sqrt #(
        .RAD_W(RAD_W)
    ) u_root (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_start(root_start),
        .i_radicand(radicand),
        .o_root(root_val),
        .o_done(root_done),
        .o_busy()
    );

    // ------------------------------------------------------------------
    // channel sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_r <= rms_engine_pkg::ST_IDLE;
            ch_r <= '0;
            frame_done_r <= 1'b0;
        end else begin
            frame_done_r <= 1'b0;
            case (state_r)
                rms_engine_pkg::ST_IDLE: begin
                    if (i_sample_strobe) begin
                        ch_r <= '0;
                        state_r <= rms_engine_pkg::ST_FILT;
                    end
                end
                rms_engine_pkg::ST_FILT: begin
                    state_r <= rms_engine_pkg::ST_ROOT;
                end
                rms_engine_pkg::ST_ROOT: begin
                    if (root_done) begin
                        if (ch_r == CH_LAST) begin
                            state_r <= rms_engine_pkg::ST_IDLE;
                            frame_done_r <= 1'b1;
                        end else begin
                            ch_r <= ch_r + 1'b1;
                            state_r <= rms_engine_pkg::ST_FILT;
                        end
                    end
                end
                default: begin
                    state_r <= rms_engine_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // filter memory, one word per channel
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            for (int k = 0; k < NCH; k++) begin
                acc_r[k] <= '0;
            end
        end else if (state_r == rms_engine_pkg::ST_FILT) begin
            acc_r[ch_r] <= acc_new; // [RL21]
        end
    end

    // results, saturated to the positive 24-bit range
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            for (int k = 0; k < NCH; k++) begin
                res_r[k] <= '0;
            end
        end else if ((state_r == rms_engine_pkg::ST_ROOT) && root_done) begin
            res_r[ch_r] <= sat_res(root_val); // [RL1] [RL2] [RL3] [RL6]
        end
    end

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            accumulation_mode_config_r <= rms_engine_pkg::ACCUMULATION_MODE_CONFIG_RST;
            config_r <= rms_engine_pkg::CONFIG_RST;
            for (int k = 0; k < NCH; k++) begin
                off_r[k] <= '0;
            end
        end else if (i_reg_wr) begin
            if (i_reg_addr == rms_engine_pkg::ADDR_ACCUMULATION_MODE_CONFIG) begin
                accumulation_mode_config_r <= i_reg_wdata[7:0];
            end
            if (i_reg_addr == rms_engine_pkg::ADDR_CONFIG) begin
                config_r <= i_reg_wdata[15:0];
            end
            if (in_block(i_reg_addr, rms_engine_pkg::OFF_BASE)) begin
                off_r[blk_idx(i_reg_addr, rms_engine_pkg::OFF_BASE)] <= i_reg_wdata[23:0]; // [RL13]
            end
        end
    end

    logic rd_res_hit;
    logic rd_off_hit;
    logic [IN_W-1:0] rd_off;

    assign rd_res_hit = in_block(i_reg_addr, rms_engine_pkg::RES_BASE);
    assign rd_off_hit = in_block(i_reg_addr, rms_engine_pkg::OFF_BASE);
    assign rd_off = off_r[blk_idx(i_reg_addr, rms_engine_pkg::OFF_BASE)];

    // read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= i_reg_rd;
            if (i_reg_rd) begin
                if (rd_res_hit) begin
                    rdata_r <= {8'h00, res_r[blk_idx(i_reg_addr, rms_engine_pkg::RES_BASE)]}; // [RL10]
                end else if (rd_off_hit) begin
                    rdata_r <= {4'h0, {4{rd_off[IN_W-1]}}, rd_off}; // [RL14]
                end else if (i_reg_addr == rms_engine_pkg::ADDR_ACCUMULATION_MODE_CONFIG) begin
                    rdata_r <= {24'h000000, accumulation_mode_config_r};
                end else if (i_reg_addr == rms_engine_pkg::ADDR_CONFIG) begin
                    rdata_r <= {16'h0000, config_r};
                end else begin
                    rdata_r <= '0;
                end
            end
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_vb_synth = vb_synth_r;
    assign o_frame_done = frame_done_r;
    assign o_busy = (state_r != rms_engine_pkg::ST_IDLE);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_frame_start;
        frame_start;
    endsequence

    sequence s_frame_end;
        frame_done_r && (ch_r == CH_LAST);
    endsequence

    a_frame_refresh: assert property (s_frame_start |-> ##[1:FRAME_BOUND] s_frame_end) // [RL1] [RL2]
        else $error("rms frame not refreshed in time");
    a_b_power_zero: assert property (o_phase_b_power_zero
        == (topology == rms_engine_pkg::TOPO_DELTA3W)) // [RL16]
        else $error("phase b power blanking wrong");
    a_synth_line: assert property (frame_start && (topology == rms_engine_pkg::TOPO_DELTA3W)
        |=> o_vb_synth == $past(diff_3w)) // [RL15]
        else $error("phase b line voltage wrong");
    a_synth_negated: assert property (frame_start && (topology == rms_engine_pkg::TOPO_DELTA4W)
        |=> o_vb_synth == $past(neg_4w)) // [RL18]
        else $error("phase b negated voltage wrong");
    a_neutral_sum: assert property (frame_start && nsel
        |=> smp_r[rms_engine_pkg::CH_IN] == $past(isum)) // [RL5]
        else $error("neutral not phase sum");
    a_neutral_meas: assert property (frame_start && !nsel
        |=> smp_r[rms_engine_pkg::CH_IN] == $past(in_ext)) // [RL4]
        else $error("neutral not measured current");
    a_clamp_zero: assert property (root_start && rad_sum[SUM_W-1]
        |-> ##[1:ROOT_BOUND] (root_done && (root_val == '0))) // [RL22]
        else $error("negative radicand not clamped");
    a_offset_add: assert property (root_start && !rad_sum[SUM_W-1]
        |-> $signed({2'b00, radicand}) - $signed({2'b00, mean_new}) == (off_ext * 128)) // [RL11] [RL12]
        else $error("offset not scaled by 128");
    a_read_pad: assert property (i_reg_rd && rd_res_hit |=> o_reg_rvalid
        && (o_reg_rdata[31:24] == 8'h00)) // [RL10]
        else $error("rms read not zero padded");
    a_offset_pad: assert property (i_reg_rd && rd_off_hit && !rd_res_hit |=> o_reg_rvalid
        && (o_reg_rdata[31:28] == 4'h0) && (o_reg_rdata[27:24] == {4{o_reg_rdata[23]}})) // [RL14]
        else $error("offset read not sign extended");

endmodule

// ### verification/rms_sample_source.sv
// upstream sample source model for the rms engine bench
// assumes the bench sets levels and enable; sign flips on every strobe
`timescale 1ns/1ps
module rms_sample_source (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_en,
    input wire logic i_done,
    input wire logic signed [23:0] i_lvl [21],
    output logic o_strobe,
    output logic o_neg,
    output logic signed [23:0] o_smp [21]
);
    // ------------------------------------------------------------
    // strobe four cycles after each frame, garbage between strobes
    // ------------------------------------------------------------
    logic [2:0] cnt_r;
    initial begin
        cnt_r = 3'h0;
        o_strobe = 1'b0;
        o_neg = 1'b0;
        for (int k = 0; k < 21; k++) o_smp[k] = 24'h000000;
    end
    always @(posedge i_clk) begin
        o_strobe <= (cnt_r == 3'h3);
        cnt_r <= (!i_rstn || !i_en || i_done) ? 3'h0 : (cnt_r == 3'h4) ? cnt_r : cnt_r + 3'h1;
        if (cnt_r == 3'h3) o_neg <= !o_neg;
        for (int k = 0; k < 21; k++)
            o_smp[k] <= (cnt_r == 3'h3) ? (o_neg ? i_lvl[k] : -i_lvl[k]) : ~o_smp[k];
    end
endmodule

// ### verification/test_polyphase_rms_engine.sv
// self-checking bench for the polyphase rms engine
// assumes the sample source model and a short filter pole
`timescale 1ns/1ps
module test_polyphase_rms_engine;
    logic i_clk = 0, i_rstn = 0, wr = 0, rd = 0, en = 0, sel = 0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic rvalid, strobe, neg, pzero, done, busy;
    logic signed [24:0] vbs;
    logic signed [23:0] lvl [21], smp [21], off [18];
    int mismatches = 0, checks = 0, cyc = 0;
    // ------------------------------------------------------------
    // clock, watchdog and instances
    // ------------------------------------------------------------
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            mismatches++;
            finish_test();
        end
    end
    rms_sample_source u_rms_sample_source (.i_clk, .i_rstn, .i_en(en), .i_done(done),
        .i_lvl(lvl), .o_strobe(strobe), .o_neg(neg), .o_smp(smp));
    polyphase_rms_engine #(.LPF_SHIFT(2)) u_polyphase_rms_engine (.i_clk, .i_rstn,
        .i_sample_strobe(strobe), .i_ia(smp[0]), .i_ib(smp[1]), .i_ic(smp[2]), .i_in(smp[3]),
        .i_va(smp[4]), .i_vb(smp[5]), .i_vc(smp[6]), .i_vn(smp[7]), .i_va2(smp[8]),
        .i_vb2(smp[9]), .i_vc2(smp[10]), .i_vn2(smp[11]), .i_ia_fund(smp[12]),
        .i_ib_fund(smp[13]), .i_ic_fund(smp[14]), .i_va_fund(smp[15]), .i_vb_fund(smp[16]),
        .i_vc_fund(smp[17]), .i_va_raw(smp[18]), .i_vb_raw(smp[19]), .i_vc_raw(smp[20]),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_vb_synth(vbs),
        .o_phase_b_power_zero(pzero), .o_frame_done(done), .o_busy(busy));
    task finish_test;
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e, input int t);
        checks++;
        if (!(((s + t >= e) && (s <= e + t)) === 1'b1)) begin
            mismatches++;
            $display("wrong value at %0t: saw %0h expected %0h", $time, s, e);
        end
    endtask
    task wreg(input logic [15:0] a, input logic [31:0] v);
        @(posedge i_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [15:0] a, input logic [31:0] e, input int t);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        chk(rvalid, 32'h1, 0);
        chk(rdata, e, t);
    endtask
    task frames(input int n);
        repeat (n) do @(posedge i_clk); while (done !== 1'b1);
        #1;
    endtask
    // expected rms from level, offset and neutral source, negative radicand gives 0
    function automatic longint exp_rms(input int k);
        longint l, v, r;
        l = (k == 3 && sel) ? lvl[0] + lvl[1] + lvl[2] : lvl[k];
        v = l * l + 128 * longint'(off[k]);
        r = 0;
        while ((r + 1) * (r + 1) <= v) r++;
        return r;
    endfunction
    task results;
        for (int k = 0; k < 18; k++)
            rreg(rms_engine_pkg::RES_BASE + 16'(k), 32'(exp_rms(k)), 2);
    endtask
    initial begin
        void'($urandom(56));
        for (int k = 0; k < 21; k++) lvl[k] = 24'(100 + $urandom % 1900);
        for (int k = 0; k < 18; k++) off[k] = 24'h000000;
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        rreg(rms_engine_pkg::ADDR_CONFIG, 32'h00000000, 0);
        rreg(16'h1234, 32'h00000000, 0);
        wreg(rms_engine_pkg::ADDR_ACCUMULATION_MODE_CONFIG, 32'h00000010);
        rreg(rms_engine_pkg::ADDR_ACCUMULATION_MODE_CONFIG, 32'h00000010, 0);
        chk(pzero, 32'h1, 0);
        en <= 1'b1;
        frames(64);
        chk(vbs, neg ? lvl[20] - lvl[18] : lvl[18] - lvl[20], 0);
        wreg(rms_engine_pkg::ADDR_ACCUMULATION_MODE_CONFIG, 32'h00000030);
        frames(2);
        chk(vbs, neg ? lvl[18] : -lvl[18], 0);
        chk(pzero, 32'h0, 0);
        chk(busy, 32'h0, 0);
        results();
        for (int k = 0; k < 18; k++) begin
            off[k] = (k == 17) ? 24'h800000 : 24'($urandom % 65536) - 24'h008000;
            wreg(rms_engine_pkg::OFF_BASE + 16'(k), {8'h00, off[k]});
            rreg(rms_engine_pkg::OFF_BASE + 16'(k), {4'h0, {4{off[k][23]}}, off[k]}, 0);
        end
        wreg(rms_engine_pkg::ADDR_CONFIG, 32'h00004000);
        sel = 1'b1;
        frames(64);
        results();
        finish_test();
    end
endmodule
